// ### hw/scc_ctrl.v
// Synchronous serial channel: banked control register and shift engine
//
// Overview of operation
// [RULE_01] Enable and master bits always accessible
// [RULE_02] Bits 13..0 banked: config or status
// [RULE_03] Bank chosen by enable before the access
// [RULE_04] Disabling write stores bits into flag bank
// [RULE_05] Reset clears control register to zero
// [RULE_06] Clearing enable halts clock, aborts transfer
// [RULE_07] Disabled: clock and data outputs high
// [RULE_08] Master drives clock and starts transfers
// [RULE_09] Slave takes clock, never starts transfers
// [RULE_10] Other nodes are slaves while we master
// [RULE_11] Width field plus one gives bit count
// [RULE_12] Enabled: low bits read bit counter
// [RULE_13] Bit 4 selects MSB or LSB first
// [RULE_14] Buffers stay right aligned at bit 0
// [RULE_15] Polarity bit 6, phase bit 5
// [RULE_16] Bits 11..8 error enables or flags
// [RULE_17] Busy flag at bit 12 when enabled
// [RULE_18] Software writes zero to undefined bits
// [RULE_19] Software avoids read-modify-write while enabled
// [RULE_20] Polarity sets clock idle level
// [RULE_21] Phase picks latch edge versus shift edge
// [RULE_22] Enabled: counter updates on every shift; code steps it on latch edges only
// [RULE_23] Config readback; flags persist until overwritten
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scc_defines.vh"

module scc_ctrl (
	input  wire        sys_clk,
	input  wire        rst_n,
	input  wire [15:0] addr,
	input  wire [15:0] wr_data,
	input  wire        wr_stb,
	input  wire        rd_stb,
	output reg  [15:0] rd_data,
	input  wire        shift_clock_pin_i,
	output wire        shift_clock_pin_o,
	output wire        shift_clock_pin_oe_n,
	input  wire        master_out_slave_in_pin_i,
	output wire        master_out_slave_in_pin_o,
	output wire        master_out_slave_in_pin_oe_n,
	input  wire        master_in_slave_out_pin_i,
	output wire        master_in_slave_out_pin_o,
	output wire        master_in_slave_out_pin_oe_n
);

	// Always-visible control bits
	reg        channel_enable_reg;
	reg        master_select_reg;
	// Configuration bank
	reg [3:0]  err_check_en_reg;   // Baud, phase, rx, tx checks
	reg        clock_polarity_reg;
	reg        clock_phase_reg;
	reg        msb_first_select_reg;
	reg [3:0]  data_width_field_reg;
	// Status bank
	reg [3:0]  err_flag_reg;
	reg        transfer_busy_flag_reg;
	reg [3:0]  bit_counter_field_reg; // Bits latched so far
	// Shift engine
	reg [4:0]  edge_cnt_reg;       // Clock edges in this frame
	reg [15:0] shifter_reg;
	reg        out_bit_reg;        // Bit driven on the data pin
	reg        sclk_reg;           // Generated clock level
	reg        sclk_prev_reg;      // Last sampled slave clock
	// Buffers
	reg [15:0] transmit_buffer_reg;
	reg        tx_full_reg;
	reg [15:0] receive_buffer_reg;
	reg        rx_unread_reg;

	wire       tick;
	wire [15:0] shift_next;
	reg  [3:0] err_set;
	reg  [15:0] rd_next;

	// Strobe decode
	wire wr_ctrl = wr_stb && (addr == `SCC_ADDR_CTRL);
	wire wr_txb  = wr_stb && (addr == `SCC_ADDR_TXBUF);
	wire rd_rxb  = rd_stb && (addr == `SCC_ADDR_RXBUF);

	// Short names for the running mode
	wire en   = channel_enable_reg;
	wire ms   = master_select_reg;
	wire busy = transfer_busy_flag_reg;

	// Master clock tick runs only during a master frame
	scc_tick u_tick (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.run     (en && ms && busy),   // [RULE_06] [RULE_08]
		.tick    (tick)
	);

	// Slave sees an edge whenever the sampled pin changes
	wire slave_edge = en && !ms && (shift_clock_pin_i != sclk_prev_reg); // [RULE_09]

	// Clock edge that concerns this node
	wire edge_now = ms ? tick : slave_edge;

	// Level before the edge; leading edge leaves idle level
	wire level_before = ms ? sclk_reg : sclk_prev_reg;
	wire lead = (level_before == clock_polarity_reg);       // [RULE_20]

	// Phase 1 latches on the leading edge, phase 0 on trailing
	wire latch_edge = edge_now && busy && (lead == clock_phase_reg); // [RULE_21]
	wire shift_edge = edge_now && busy && (lead != clock_phase_reg); // [RULE_21]

	// Incoming bit depends on which side we are
	wire rx_bit = ms ? master_in_slave_out_pin_i : master_out_slave_in_pin_i;

	// Last latch of the frame: counter hits width minus one
	wire last_latch = latch_edge && (bit_counter_field_reg == data_width_field_reg); // [RULE_11]

	// Master frame is 2n edges; the clock ends back at idle
	wire [4:0] last_edge = {data_width_field_reg, 1'b1};
	wire master_done = ms && edge_now && busy && (edge_cnt_reg == last_edge);
	wire done = ms ? master_done : last_latch;

	// Next frame starts at once from a full transmit buffer
	wire start = en && tx_full_reg && (!busy || done);

	// Slave clock edge with nothing loaded
	wire tx_underrun = slave_edge && !busy;

	// Per-bit shift; data kept right aligned in any order
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_shift
			if (gi == 0) begin : g_lo
				assign shift_next[gi] = msb_first_select_reg ? rx_bit :
					((data_width_field_reg == 4'h0) ? rx_bit : shifter_reg[1]);
			end else if (gi == 15) begin : g_hi
				// Bits above the frame stay zero in either order
				assign shift_next[gi] = msb_first_select_reg ?
					((data_width_field_reg == 4'hF) ? shifter_reg[14] : 1'b0) :
					((data_width_field_reg == 4'hF) ? rx_bit : 1'b0);
			end else begin : g_mid
				// Position as a plain vector for width compares
				localparam [31:0] POS_W = gi;
				assign shift_next[gi] = msb_first_select_reg ?
					((data_width_field_reg >= POS_W[3:0]) ? shifter_reg[gi-1] : 1'b0) :
					((data_width_field_reg == POS_W[3:0]) ? rx_bit :
					 ((data_width_field_reg > POS_W[3:0]) ? shifter_reg[gi+1] : 1'b0));
			end
		end
	endgenerate // [RULE_13] [RULE_14]

	// First bit out of a word: top used bit or bit 0
	function head_bit;
		input [15:0] word;
		input [3:0]  width;
		input        msbf;
		begin
			head_bit = msbf ? word[width] : word[0];
		end
	endfunction

	// Hardware error events
	always @* begin
		err_set = 4'h0;
		// Receive overrun: new word while old one unread
		err_set[`SCC_ERR_RX] = done && rx_unread_reg &&
			err_check_en_reg[`SCC_ERR_RX];                 // [RULE_16]
		// Transmit underrun: slave clocked while empty
		err_set[`SCC_ERR_TX] = tx_underrun &&
			err_check_en_reg[`SCC_ERR_TX];                 // [RULE_16]
	end

	// Always-visible bits and configuration bank
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			channel_enable_reg   <= 1'b0;                // [RULE_05]
			master_select_reg    <= 1'b0;                // [RULE_05]
			err_check_en_reg     <= 4'h0;
			clock_polarity_reg   <= 1'b0;
			clock_phase_reg      <= 1'b0;
			msb_first_select_reg <= 1'b0;
			data_width_field_reg <= 4'h0;
		end else if (wr_ctrl) begin
			// Top bits written in either bank
			channel_enable_reg <= wr_data[`SCC_BIT_EN];  // [RULE_01]
			master_select_reg  <= wr_data[`SCC_BIT_MS];  // [RULE_01]
			// Old enable value picks the bank
			if (!en) begin                               // [RULE_03]
				err_check_en_reg     <= wr_data[`SCC_ERR_HI:`SCC_ERR_LO]; // [RULE_16]
				clock_polarity_reg   <= wr_data[`SCC_BIT_POL];  // [RULE_15]
				clock_phase_reg      <= wr_data[`SCC_BIT_PHA];  // [RULE_15]
				msb_first_select_reg <= wr_data[`SCC_BIT_MSBF]; // [RULE_13]
				data_width_field_reg <= wr_data[`SCC_CNT_HI:0]; // [RULE_11]
			end
		end
	end

	// Error flags: software writes only via status bank
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_flag_reg <= 4'h0;
		end else if (wr_ctrl && en) begin
			// Hardware set wins over a software clear
			err_flag_reg <= wr_data[`SCC_ERR_HI:`SCC_ERR_LO] | err_set; // [RULE_04]
		end else begin
			err_flag_reg <= err_flag_reg | err_set;     // [RULE_23]
		end
	end

	// Shift engine, busy flag and bit counter
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			transfer_busy_flag_reg <= 1'b0;
			bit_counter_field_reg  <= 4'h0;
			edge_cnt_reg           <= 5'h00;
			shifter_reg            <= `SCC_BUF_RESET;
			out_bit_reg            <= 1'b1;
			sclk_reg               <= 1'b1;
		end else if (!en) begin
			// Disabled: abort frame, pins back to high
			transfer_busy_flag_reg <= 1'b0;          // [RULE_06]
			bit_counter_field_reg  <= 4'h0;          // [RULE_06]
			edge_cnt_reg           <= 5'h00;
			out_bit_reg            <= 1'b1;          // [RULE_07]
			sclk_reg               <= 1'b1;          // [RULE_07]
		end else if (start) begin
			// Load from the transmit buffer; slave waits for clock
			transfer_busy_flag_reg <= 1'b1;          // [RULE_17]
			bit_counter_field_reg  <= 4'h0;
			edge_cnt_reg           <= 5'h00;
			shifter_reg            <= transmit_buffer_reg;
			out_bit_reg            <= head_bit(transmit_buffer_reg,
				data_width_field_reg, msb_first_select_reg);
			// Final master edge already returns to idle
			sclk_reg               <= clock_polarity_reg; // [RULE_20]
		end else if (done) begin
			transfer_busy_flag_reg <= 1'b0;
			bit_counter_field_reg  <= 4'h0;
			edge_cnt_reg           <= 5'h00;
			if (latch_edge) begin
				shifter_reg <= shift_next;
			end
			sclk_reg <= clock_polarity_reg;
		end else if (busy && edge_now) begin
			// Master clock toggles on every tick
			if (ms) begin
				sclk_reg <= ~sclk_reg;               // [RULE_08]
			end
			edge_cnt_reg <= edge_cnt_reg + 5'h01;
			if (latch_edge) begin
				// Sample the line into the word
				shifter_reg           <= shift_next;
				bit_counter_field_reg <= bit_counter_field_reg + 4'h1; // [RULE_22]
			end
			if (shift_edge) begin
				// Present the next bit on the line
				out_bit_reg <= head_bit(shifter_reg,
					data_width_field_reg, msb_first_select_reg); // [RULE_21]
			end
		end else if (!busy) begin
			// Idle: clock rests at the polarity level
			sclk_reg <= clock_polarity_reg;          // [RULE_20]
		end
	end

	// Slave clock history for edge detection
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_reg <= 1'b0;
		end else if (!en || ms) begin
			// Track idle level so enabling makes no false edge
			sclk_prev_reg <= clock_polarity_reg;
		end else begin
			sclk_prev_reg <= shift_clock_pin_i;
		end
	end

	// Transmit buffer; load into the shifter empties it
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_buffer_reg <= `SCC_BUF_RESET;
			tx_full_reg         <= 1'b0;
		end else if (wr_txb) begin
			transmit_buffer_reg <= wr_data;              // [RULE_14]
			tx_full_reg         <= 1'b1;
		end else if (start) begin
			tx_full_reg <= 1'b0;
		end
	end

	// Receive buffer; a finished frame overwrites it
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			receive_buffer_reg <= `SCC_BUF_RESET;
			rx_unread_reg      <= 1'b0;
		end else if (en && done) begin
			// Word lands right aligned; new data beats a read
			receive_buffer_reg <= latch_edge ? shift_next : shifter_reg; // [RULE_14]
			rx_unread_reg      <= 1'b1;
		end else if (rd_rxb) begin
			rx_unread_reg <= 1'b0;
		end
	end

	// Read mux; the old enable value picks the bank
	always @* begin
		rd_next = 16'h0000;
		case (addr)
			`SCC_ADDR_CTRL: begin
				rd_next[`SCC_BIT_EN] = en;                   // [RULE_01]
				rd_next[`SCC_BIT_MS] = ms;                   // [RULE_01]
				if (en) begin                                // [RULE_02]
					rd_next[`SCC_BIT_BUSY] = busy;           // [RULE_17]
					rd_next[`SCC_ERR_HI:`SCC_ERR_LO] = err_flag_reg; // [RULE_16]
					rd_next[`SCC_CNT_HI:0] = bit_counter_field_reg;  // [RULE_12]
				end else begin
					rd_next[`SCC_ERR_HI:`SCC_ERR_LO] = err_check_en_reg; // [RULE_23]
					rd_next[`SCC_BIT_POL]  = clock_polarity_reg;
					rd_next[`SCC_BIT_PHA]  = clock_phase_reg;
					rd_next[`SCC_BIT_MSBF] = msb_first_select_reg;
					rd_next[`SCC_CNT_HI:0] = data_width_field_reg;   // [RULE_23]
				end
			end
			`SCC_ADDR_TXBUF: begin
				rd_next = transmit_buffer_reg;
			end
			`SCC_ADDR_RXBUF: begin
				rd_next = receive_buffer_reg;
			end
			default: begin
				// Unmapped addresses read as zero
				rd_next = 16'h0000;
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 16'h0000;
		end else if (rd_stb) begin
			rd_data <= rd_next;
		end else begin
			rd_data <= 16'h0000;
		end
	end

	// Pin drive: master owns clock and out line, slave the in line
	assign shift_clock_pin_o            = sclk_reg;          // [RULE_07]
	assign shift_clock_pin_oe_n         = !(en && ms);       // [RULE_08] [RULE_09]
	assign master_out_slave_in_pin_o    = out_bit_reg;       // [RULE_07]
	assign master_out_slave_in_pin_oe_n = !(en && ms);       // [RULE_08]
	assign master_in_slave_out_pin_o    = out_bit_reg;       // [RULE_07]
	assign master_in_slave_out_pin_oe_n = !(en && !ms);      // [RULE_09]

endmodule
`default_nettype wire

// ### hw/scc_defines.vh
// Register map, field positions, reset values and timing for the serial channel
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH

// Register addresses on the plain register port
`define SCC_ADDR_CTRL   16'hFFB2
`define SCC_ADDR_TXBUF  16'hFFB4
`define SCC_ADDR_RXBUF  16'hFFB6

// Control register field positions
`define SCC_BIT_EN      15
`define SCC_BIT_MS      14
`define SCC_BIT_BUSY    12
`define SCC_ERR_HI      11
`define SCC_ERR_LO      8
`define SCC_BIT_POL     6
`define SCC_BIT_PHA     5
`define SCC_BIT_MSBF    4
`define SCC_CNT_HI      3

// Positions inside the four-bit error group
`define SCC_ERR_BAUD    3
`define SCC_ERR_PHASE   2
`define SCC_ERR_RX      1
`define SCC_ERR_TX      0

// Reset values
`define SCC_CTRL_RESET  16'h0000
`define SCC_BUF_RESET   16'h0000

// Shift clock half period in ns, clock rate in MHz
`define SCC_HALF_NS     200
`define SCC_CLK_MHZ     25
// Half period in cycles, rounded down, at least one
`define SCC_HALF_CYC    (((`SCC_HALF_NS * `SCC_CLK_MHZ) / 1000) < 1 ? 1 : \
                         ((`SCC_HALF_NS * `SCC_CLK_MHZ) / 1000))
`define SCC_DIV_W       8

`endif

// ### hw/scc_tick.v
// Half-period tick generator for the master shift clock
`timescale 1ns/1ps
`default_nettype none
`include "scc_defines.vh"

module scc_tick (
	input  wire       sys_clk,
	input  wire       rst_n,
	input  wire       run,
	output reg        tick
);

	// Down counter, reloaded whenever the channel stops
	reg [`SCC_DIV_W-1:0] div_reg;

	// Reload computed wide, then cut to the counter width on purpose
	localparam [31:0]           RELOAD_W = `SCC_HALF_CYC - 1;
	localparam [`SCC_DIV_W-1:0] RELOAD   = RELOAD_W[`SCC_DIV_W-1:0];

	// Counter and tick pulse; held in reload while idle
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 8'h00;
			tick    <= 1'b0;
		end else if (!run) begin
			div_reg <= RELOAD;
			tick    <= 1'b0;
		end else if (div_reg == 8'h00) begin
			div_reg <= RELOAD;
			tick    <= 1'b1;
		end else begin
			div_reg <= div_reg - 8'h01;
			tick    <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ### tb/scc_ctrl_monitor.sv
// Port-level checker for the serial channel control block
`timescale 1ns/1ps
`default_nettype none
`include "scc_defines.vh"
module scc_ctrl_monitor (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic [15:0] addr,
	input wire logic [15:0] wr_data,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [15:0] rd_data,
	input wire logic        shift_clock_pin_i,
	input wire logic        shift_clock_pin_o,
	input wire logic        shift_clock_pin_oe_n,
	input wire logic        master_out_slave_in_pin_i,
	input wire logic        master_out_slave_in_pin_o,
	input wire logic        master_out_slave_in_pin_oe_n,
	input wire logic        master_in_slave_out_pin_i,
	input wire logic        master_in_slave_out_pin_o,
	input wire logic        master_in_slave_out_pin_oe_n
);
	logic        en_reg;   // Enable as last written
	logic        ms_reg;   // Master select as last written
	logic [11:0] cfg_reg;  // Shadow of the config bank
	wire         ctl_hit = addr == `SCC_ADDR_CTRL;
	wire         rd_ctrl = rd_stb && ctl_hit;
	wire         rd_map  = rd_stb && (ctl_hit || addr == `SCC_ADDR_TXBUF || addr == `SCC_ADDR_RXBUF);
	wire [1:0]   top     = {en_reg, ms_reg};
	wire [10:0]  cfg_vw  = {cfg_reg[11:8], cfg_reg[6:0]};  // Bit 7 is undefined, left out
	wire         pol_w   = wr_data[6];
	wire         en_wr   = wr_stb && ctl_hit && !en_reg && wr_data[15] && wr_data[14];
	// Shadow tracks the bank chosen by enable before each write
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{en_reg, ms_reg, cfg_reg} <= 14'h0000;
		end else if (wr_stb && ctl_hit) begin
			{en_reg, ms_reg} <= wr_data[15:14];
			if (!en_reg) begin
				cfg_reg <= wr_data[11:0];
			end
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	AST_EN_MS: assert property (
		$past(rd_ctrl) |-> rd_data[15:14] == $past(top))
		else $error("enable or master bit readback wrong");
	AST_CFG_BANK: assert property (
		$past(rd_ctrl) && !$past(en_reg) |-> {rd_data[11:8], rd_data[6:0]} == $past(cfg_vw))
		else $error("config bank readback wrong");
	AST_RD_ZERO: assert property (
		!$past(rd_map) |-> rd_data == 16'h0000)
		else $error("read data not zero outside a mapped read");
	AST_DIS_IDLE: assert property (
		!en_reg && !$past(en_reg) |-> shift_clock_pin_o && master_out_slave_in_pin_o
			&& master_in_slave_out_pin_o && shift_clock_pin_oe_n
			&& master_out_slave_in_pin_oe_n && master_in_slave_out_pin_oe_n)
		else $error("pins not released high while disabled");
	AST_OE_MASTER: assert property (
		en_reg && $past(en_reg) && ms_reg && $past(ms_reg) |-> !shift_clock_pin_oe_n
			&& !master_out_slave_in_pin_oe_n && master_in_slave_out_pin_oe_n)
		else $error("master pin enables wrong");
	AST_OE_SLAVE: assert property (
		en_reg && $past(en_reg) && !ms_reg && !$past(ms_reg) |-> shift_clock_pin_oe_n
			&& master_out_slave_in_pin_oe_n && !master_in_slave_out_pin_oe_n)
		else $error("slave pin enables wrong");
	AST_IDLE_POL: assert property (
		en_wr |-> ##2 shift_clock_pin_o == $past(pol_w, 2))
		else $error("clock idle level differs from polarity");
	AST_HALF_PER: assert property (
		en_reg && $past(en_reg) && ms_reg && $changed(shift_clock_pin_o)
			|=> (!en_reg || $stable(shift_clock_pin_o)) [*4])
		else $error("shift clock half period too short");
endmodule
`default_nettype wire

// ### tb/scc_spi_slave.sv
// Behavioural serial slave standing on the far side of the channel
`timescale 1ns/1ps
`default_nettype none
module scc_spi_slave (
	input wire logic        sys_clk,
	input wire logic        sclk,
	input wire logic        mosi,
	input wire logic        cpol,
	input wire logic        cpha,
	input wire logic        msbf,
	input wire logic        load,
	input wire logic [3:0]  width,
	input wire logic [15:0] tx_word,
	output logic            miso,
	output logic [15:0]     rx_word
);
	logic sclk_q = 1'b0;  // Last clock sample
	int   cnt = 16;       // Bits latched this frame
	int   n = 16;         // Frame length
	// Wire order to buffer position, data kept right aligned
	function automatic int pos(input int k);
		return msbf ? n - 1 - k : k;
	endfunction
	initial begin
		miso = 1'b1;
		rx_word = 16'h0000;
	end
	// Only follows the clock it is given, never starts a frame
	always @(posedge sys_clk) begin
		n = int'(width) + 1;
		if (load) begin
			cnt = 0;
			rx_word <= 16'h0000;
			miso <= tx_word[pos(0)];
		end else if (sclk !== sclk_q && cnt < n) begin
			// Leading edge latches when phase is 1, else trailing
			if ((sclk !== cpol) == cpha) begin
				rx_word[pos(cnt)] <= mosi;
				cnt = cnt + 1;
				if (cnt == n) begin
					miso <= ~miso;  // Inverted: no stale last bit
				end
			end else begin
				miso <= tx_word[pos(cnt)];
			end
		end
		sclk_q = sclk;
	end
endmodule
`default_nettype wire

// ### tb/scc_ctrl_tb.sv
// Register-level testbench for the serial channel control block
`timescale 1ns/1ps
`default_nettype none
`include "scc_defines.vh"
module scc_ctrl_tb;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wr_data = 16'h0000;
	wire  [15:0] rd_data;
	wire         shift_clock_pin_o, shift_clock_pin_oe_n;
	wire         master_out_slave_in_pin_o, master_out_slave_in_pin_oe_n;
	wire         master_in_slave_out_pin_o, master_in_slave_out_pin_oe_n;
	logic        tb_sclk = 1'b0;  // Bench master clock in slave test
	logic        tb_mosi = 1'b0;  // Bench master data in slave test
	logic        s_load = 1'b0, s_pol = 1'b0, s_pha = 1'b0, s_msb = 1'b0;
	logic [3:0]  s_w = 4'h0;
	logic [15:0] s_tx = 16'h0000;
	wire  [15:0] s_rx;
	wire         s_miso;
	int          failures = 0;
	int          checks_done = 0;
	// Wire levels resolved from the channel's enables; the bench drives otherwise
	wire shift_clock_pin_i = shift_clock_pin_oe_n ? tb_sclk : shift_clock_pin_o;
	wire master_out_slave_in_pin_i = master_out_slave_in_pin_oe_n ? tb_mosi
		: master_out_slave_in_pin_o;
	wire master_in_slave_out_pin_i = master_in_slave_out_pin_oe_n ? s_miso
		: master_in_slave_out_pin_o;
	scc_ctrl dut (.sys_clk, .rst_n, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
		.shift_clock_pin_i, .shift_clock_pin_o, .shift_clock_pin_oe_n,
		.master_out_slave_in_pin_i, .master_out_slave_in_pin_o,
		.master_out_slave_in_pin_oe_n, .master_in_slave_out_pin_i,
		.master_in_slave_out_pin_o, .master_in_slave_out_pin_oe_n);
	scc_spi_slave u_slv (.sys_clk(sys_clk), .sclk(shift_clock_pin_i),
		.mosi(master_out_slave_in_pin_i), .cpol(s_pol), .cpha(s_pha), .msbf(s_msb),
		.load(s_load), .width(s_w), .tx_word(s_tx), .miso(s_miso), .rx_word(s_rx));
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		#1 d = rd_data;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic pins_idle();
		repeat (2) @(posedge sys_clk);
		#1 chk("pins", 16'h003F, {10'h000, shift_clock_pin_o, master_out_slave_in_pin_o,
			master_in_slave_out_pin_o, shift_clock_pin_oe_n,
			master_out_slave_in_pin_oe_n, master_in_slave_out_pin_oe_n});
	endtask
	// Poll busy under a bounded count
	task automatic wait_idle();
		int k;
		logic [15:0] v;
		v = 16'hFFFF;
		for (k = 0; k < 200 && v[12] !== 1'b0; k++) rd(`SCC_ADDR_CTRL, v);
		chk("busy_end", 16'h0000, v & 16'h1000);
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Hang guard, well beyond the expected run
	initial begin
		#(40 * 20000);
		failures++;
		give_verdict();
	end
	initial begin
		logic [15:0] v, c, m;
		logic [3:0] w;
		int i;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(`SCC_ADDR_CTRL, v);
		chk("ctrl_reset", 16'h0000, v);
		rd(16'h0000, v);
		chk("unmapped", 16'h0000, v);
		// Every polarity and phase, widths of 16, 2, 8 and 12 bits
		for (i = 0; i < 4; i++) begin
			w = (i == 0) ? 4'hF : (i == 1) ? 4'h1 : (i == 2) ? 4'h7 : 4'hB;
			c = {8'h40, 1'b0, i[1], i[0], i[1] ^ i[0], w};
			m = 16'hFFFF >> (4'hF - w);
			{s_pol, s_pha, s_msb, s_w} <= {i[1], i[0], i[1] ^ i[0], w};
			s_tx <= 16'hB2C5 & m;
			wr(`SCC_ADDR_CTRL, c);
			rd(`SCC_ADDR_CTRL, v);
			chk("cfg_rd", c, v);
			wr(`SCC_ADDR_CTRL, c | 16'h8000);
			rd(`SCC_ADDR_CTRL, v);
			chk("status_idle", 16'hC000, v & 16'hDF0F);
			@(posedge sys_clk) s_load <= 1'b1;
			@(posedge sys_clk) s_load <= 1'b0;
			wr(`SCC_ADDR_TXBUF, 16'h6D39 & m);
			rd(`SCC_ADDR_CTRL, v);
			chk("busy_set", 16'h1000, v & 16'h1000);
			wait_idle();
			rd(`SCC_ADDR_RXBUF, v);
			chk("rx_buf", 16'hB2C5 & m, v);
			chk("far_rx", 16'h6D39 & m, s_rx);
			wr(`SCC_ADDR_CTRL, 16'h0000);
			pins_idle();
		end
		// Abort mid-frame with a disabling write that lands in the flag bank
		wr(`SCC_ADDR_CTRL, 16'h400F);
		wr(`SCC_ADDR_CTRL, 16'hC00F);
		wr(`SCC_ADDR_TXBUF, 16'hFFFF);
		repeat (20) @(posedge sys_clk);
		wr(`SCC_ADDR_CTRL, 16'h0300);
		pins_idle();
		rd(`SCC_ADDR_CTRL, v);
		chk("cfg_kept", 16'h000F, v);
		wr(`SCC_ADDR_CTRL, 16'h800F);
		rd(`SCC_ADDR_CTRL, v);
		chk("flags_kept", 16'h8300, v & 16'hDF0F);
		wr(`SCC_ADDR_CTRL, 16'h0000);
		// Slave waits for the bench clock, two-bit frame, underrun check on
		wr(`SCC_ADDR_CTRL, 16'h0101);
		wr(`SCC_ADDR_CTRL, 16'h8101);
		wr(`SCC_ADDR_TXBUF, 16'h0002);
		repeat (40) @(posedge sys_clk);
		rd(`SCC_ADDR_CTRL, v);
		chk("slave_waits", 16'h1000, v & 16'h1000);
		chk("slave_out0", 16'h0000, {15'h0, master_in_slave_out_pin_o});
		tb_mosi <= 1'b1;
		for (i = 0; i < 4; i++) begin
			repeat (5) @(posedge sys_clk);
			tb_sclk <= ~tb_sclk;
			if (i == 1) begin
				// One bit latched so far, frame still running
				rd(`SCC_ADDR_CTRL, v);
				chk("bit_count", 16'h1001, v & 16'h100F);
			end
		end
		repeat (10) @(posedge sys_clk);
		rd(`SCC_ADDR_RXBUF, v);
		chk("slave_rx", 16'h0003, v);
		chk("slave_out1", 16'h0001, {15'h0, master_in_slave_out_pin_o});
		wait_idle();
		// Clock edge with nothing loaded raises the transmit error flag
		tb_sclk <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(`SCC_ADDR_CTRL, v);
		chk("tx_err", 16'h0100, v & 16'h0F00);
		give_verdict();
	end
endmodule
bind scc_ctrl scc_ctrl_monitor u_mon (.sys_clk, .rst_n, .addr, .wr_data, .wr_stb,
	.rd_stb, .rd_data, .shift_clock_pin_i, .shift_clock_pin_o, .shift_clock_pin_oe_n,
	.master_out_slave_in_pin_i, .master_out_slave_in_pin_o,
	.master_out_slave_in_pin_oe_n, .master_in_slave_out_pin_i,
	.master_in_slave_out_pin_o, .master_in_slave_out_pin_oe_n);
`default_nettype wire
